// *** shared/acs_defines.svh ***
// Register map, field positions, reset values and timing constants of the conversion sequencer
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ACS_OFF_CTRL    8'h00
`define ACS_OFF_RES_HI  8'h04
`define ACS_OFF_RES_LO  8'h08
`define ACS_OFF_STAT    8'h0C
`define ACS_OFF_MASK    8'h10
`define ACS_OFF_STATE   8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACS_CTRL_ON     0
`define ACS_CTRL_GO     1
`define ACS_CTRL_RC     2
`define ACS_EV_DONE     0
`define ACS_EV_ABORT    1
`define ACS_ST_BUSY     0
`define ACS_ST_PWR      1
`define ACS_ST_PDOWN    2
`define ACS_RES_LO_W    8

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define ACS_RES_W       10
`define ACS_EV_W        2
`define ACS_ZERO32      32'h0000_0000
`define ACS_RESULT_RST  10'h000

// ---------------------------------------------------------------
// Timing: instruction cycle and conversion bit periods
// ---------------------------------------------------------------
`define ACS_CLK_NS      20
`define ACS_INSTR_NS    80
`define ACS_INSTR_CYC   ((`ACS_INSTR_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_TAD_SYS_NS  1000
`define ACS_TAD_RC_NS   2000
`define ACS_TAD_SYS_CYC ((`ACS_TAD_SYS_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_TAD_RC_CYC  ((`ACS_TAD_RC_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)

`endif

// *** shared/acs_pkg.sv ***
// Types shared by the conversion sequencer and its approximation engine
`include "acs_defines.svh"
package acs_pkg;

  // ---------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ACS_IDLE  = 3'b001,
    ACS_DELAY = 3'b010,
    ACS_CONV  = 3'b100
  } acs_seq_state_t;

  typedef enum logic [2:0] {
    ACS_SAR_IDLE   = 3'b001,
    ACS_SAR_SAMPLE = 3'b010,
    ACS_SAR_BITS   = 3'b100
  } acs_sar_state_t;

  // ---------------------------------------------------------------
  // APB carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } acs_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } acs_apb_rsp_t;

  // ---------------------------------------------------------------
  // Module state records
  // ---------------------------------------------------------------
  typedef struct packed {
    acs_sar_state_t        st;
    logic [7:0]            cnt;
    logic [3:0]            idx;
    logic [`ACS_RES_W-1:0] trial;
    logic [`ACS_RES_W-1:0] code;
    logic [`ACS_RES_W-1:0] result;
    logic                  last_bit;
    logic                  load;
    logic                  done;
  } acs_sar_t;

  typedef struct packed {
    acs_seq_state_t        st;
    logic                  on;
    logic                  go;
    logic                  rc_sel;
    logic                  pdown;
    logic [2:0]            dly;
    logic [`ACS_RES_W-1:0] res;
    logic [`ACS_EV_W-1:0]  flags;
    logic [`ACS_EV_W-1:0]  mask;
    logic                  cmp_s1;
    logic                  cmp_s2;
    acs_apb_rsp_t          rsp;
    logic                  irq;
    logic                  wake;
    logic                  tclr;
    logic                  aen;
  } acs_seq_t;

endpackage

// *** verilog/acs_sar.sv ***
// Successive approximation engine with early termination and partial result fill
`timescale 1ns/1ns
`include "acs_defines.svh"
module acs_sar #(
  parameter int RES_W = `ACS_RES_W
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  // Control from the sequencer
  input  wire logic             start_i,
  input  wire logic             abort_i,
  input  wire logic             kill_i,
  input  wire logic [7:0]       tad_cyc_i,
  // Comparator, already synchronised
  input  wire logic             cmp_i,
  // Results
  output logic [RES_W-1:0]      code_o,
  output logic [RES_W-1:0]      result_o,
  output logic                  load_o,
  output logic                  done_o
);
  import acs_pkg::*;

  acs_sar_t r_ff;
  acs_sar_t nxt_r;

  // Unresolved bits, the one under trial included, copy the last decided bit
  function automatic logic [RES_W-1:0] fill(input logic [RES_W-1:0] trial,
                                            input logic [3:0] idx, input logic lb);
    logic [RES_W-1:0] v;
    v = trial;
    for (int i = 0; i < RES_W; i++) begin
      if (i <= int'(idx)) begin
        v[i] = lb;
      end
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.load = 1'b0;
    nxt_r.done = 1'b0;
    unique case (r_ff.st)
      ACS_SAR_IDLE: begin
        if (start_i) begin
          nxt_r.st       = ACS_SAR_SAMPLE;
          nxt_r.cnt      = 8'h00;
          nxt_r.trial    = '0;
          nxt_r.last_bit = 1'b0;
          nxt_r.idx      = 4'(RES_W - 1);
        end
      end
      ACS_SAR_SAMPLE: begin
        nxt_r.cnt = r_ff.cnt + 8'h01;
        if (r_ff.cnt >= tad_cyc_i - 8'h01) begin
          nxt_r.st   = ACS_SAR_BITS;
          nxt_r.cnt  = 8'h00;
          nxt_r.code = RES_W'(1) << r_ff.idx;
        end
      end
      ACS_SAR_BITS: begin
        nxt_r.cnt = r_ff.cnt + 8'h01;
        if (r_ff.cnt >= tad_cyc_i - 8'h01) begin
          nxt_r.cnt             = 8'h00;
          nxt_r.trial[r_ff.idx] = cmp_i;   // Keep the bit when input is at or above trial
          nxt_r.last_bit        = cmp_i;
          if (r_ff.idx == 4'h0) begin
            nxt_r.st     = ACS_SAR_IDLE;
            nxt_r.result = nxt_r.trial;
            nxt_r.load   = 1'b1;
            nxt_r.done   = 1'b1;
          end else begin
            nxt_r.idx  = r_ff.idx - 4'h1;
            nxt_r.code = nxt_r.trial | (RES_W'(1) << (r_ff.idx - 4'h1));
          end
        end
      end
    endcase
    // Early stop keeps resolved bits and fills the rest
    if (abort_i && r_ff.st != ACS_SAR_IDLE) begin
      nxt_r.st     = ACS_SAR_IDLE;
      nxt_r.result = fill(r_ff.trial, r_ff.idx, r_ff.last_bit);
      nxt_r.load   = 1'b1;
      nxt_r.done   = 1'b0;
    end
    // A kill drops the conversion and suppresses the result load
    if (kill_i) begin
      nxt_r.st   = ACS_SAR_IDLE;
      nxt_r.load = 1'b0;
      nxt_r.done = 1'b0;
    end
    if (nxt_r.st == ACS_SAR_IDLE) begin
      nxt_r.code = '0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      r_ff <= '{st: ACS_SAR_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign code_o   = r_ff.code;
  assign result_o = r_ff.result;
  assign load_o   = r_ff.load;
  assign done_o   = r_ff.done;
endmodule

// *** verilog/acs_sequencer.sv ***
// Conversion sequencer: APB registers, start/stop control, sleep handling and events
`timescale 1ns/1ns
`include "acs_defines.svh"
// Operation
// - Writing go while enabled starts conversion
// - Completion clears go, flags, loads result
// - Clearing go early stores partial result
// - Unresolved bits copy last converted bit
// - Reset clears registers, kills conversion
// - Sleep conversions only with dedicated RC clock
// - RC clock delays start one instruction
// - Interrupt enabled: completion in sleep wakes
// - Interrupt disabled: power down, converter_on kept
// - Other clock: sleep aborts, converter_on kept
// - Trigger sets go, clears first_timer
module acs_sequencer #(
  parameter int RES_W       = `ACS_RES_W,
  parameter int TAD_SYS_CYC = `ACS_TAD_SYS_CYC,
  parameter int TAD_RC_CYC  = `ACS_TAD_RC_CYC,
  parameter int INSTR_CYC   = `ACS_INSTR_CYC
) (
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                reset_n_i,
  // APB slave
  input  wire acs_pkg::acs_apb_req_t apb_req_i,
  output acs_pkg::acs_apb_rsp_t    apb_rsp_o,
  // Core and trigger_compare_unit events, same clock
  input  wire logic                sleep_i,
  input  wire logic                trigger_i,
  // Analog comparator, asynchronous
  input  wire logic                cmp_i,
  // Outputs
  output logic [RES_W-1:0]         sar_code_o,
  output logic                     analog_en_o,
  output logic                     irq_o,
  output logic                     wake_o,
  output logic                     timer_clear_o
);
  import acs_pkg::*;

  // ---------------------------------------------------------------
  // State and engine wiring
  // ---------------------------------------------------------------
  acs_seq_t         r_ff;
  acs_seq_t         nxt_r;
  logic             sar_start;
  logic             sar_abort;
  logic             sar_kill;
  logic [RES_W-1:0] sar_code;
  logic [RES_W-1:0] sar_result;
  logic             sar_load;
  logic             sar_done;
  logic [7:0]       tad_sel;
  logic             operational;
  logic             acc;
  logic             wr_en;
  logic             go_rise;
  logic             go_fall;

  // Register read decode, shared by data and error answer
  function automatic logic [32:0] rd_word(input logic [7:0] addr, input acs_seq_t s);
    logic [31:0] d;
    logic        hit;
    d   = `ACS_ZERO32;
    hit = 1'b1;
    unique case (addr)
      `ACS_OFF_CTRL: begin
        d[`ACS_CTRL_ON] = s.on;
        d[`ACS_CTRL_GO] = s.go;
        d[`ACS_CTRL_RC] = s.rc_sel;
      end
      `ACS_OFF_RES_HI: d[RES_W-`ACS_RES_LO_W-1:0] = s.res[RES_W-1:`ACS_RES_LO_W];
      `ACS_OFF_RES_LO: d[`ACS_RES_LO_W-1:0] = s.res[`ACS_RES_LO_W-1:0];
      `ACS_OFF_STAT:   d[`ACS_EV_W-1:0] = s.flags;
      `ACS_OFF_MASK:   d[`ACS_EV_W-1:0] = s.mask;
      `ACS_OFF_STATE: begin
        d[`ACS_ST_BUSY]  = (s.st != ACS_IDLE);
        d[`ACS_ST_PWR]   = s.aen;
        d[`ACS_ST_PDOWN] = s.pdown;
      end
      default: hit = 1'b0;
    endcase
    return {hit, d};
  endfunction

  // The dedicated RC option runs the bit clock slower
  assign tad_sel = r_ff.rc_sel ? 8'(TAD_RC_CYC) : 8'(TAD_SYS_CYC);
  // Powered down in sleep counts as off even though converter_on reads one
  assign operational = r_ff.on && !r_ff.pdown;
  // One wait state: writes land on the second access cycle
  assign acc   = apb_req_i.psel && apb_req_i.penable;
  assign wr_en = acc && apb_req_i.pwrite && r_ff.rsp.pready
                 && apb_req_i.paddr == `ACS_OFF_CTRL;
  assign go_rise = wr_en && apb_req_i.pwdata[`ACS_CTRL_GO] && !r_ff.go;
  assign go_fall = wr_en && !apb_req_i.pwdata[`ACS_CTRL_GO] && r_ff.go;

  // ---------------------------------------------------------------
  // Approximation engine
  // ---------------------------------------------------------------
  acs_sar #(
    .RES_W (RES_W)
  ) u_sar (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .start_i    (sar_start),
    .abort_i    (sar_abort),
    .kill_i     (sar_kill),
    .tad_cyc_i  (tad_sel),
    .cmp_i      (r_ff.cmp_s2),
    .code_o     (sar_code),
    .result_o   (sar_result),
    .load_o     (sar_load),
    .done_o     (sar_done)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [32:0] rd;
    logic        wr_any;
    rd        = rd_word(apb_req_i.paddr, r_ff);
    wr_any    = acc && apb_req_i.pwrite && r_ff.rsp.pready;
    nxt_r     = r_ff;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    sar_kill  = 1'b0;
    nxt_r.wake = 1'b0;
    nxt_r.tclr = 1'b0;
    // Comparator passes two flops before use
    nxt_r.cmp_s1 = cmp_i;
    nxt_r.cmp_s2 = r_ff.cmp_s1;

    // APB answer: ready and data on the second access cycle
    nxt_r.rsp.pready  = acc && !r_ff.rsp.pready;
    nxt_r.rsp.pslverr = acc && !r_ff.rsp.pready && !rd[32];
    if (acc && !r_ff.rsp.pready) begin
      nxt_r.rsp.prdata = apb_req_i.pwrite ? `ACS_ZERO32 : rd[31:0];
    end

    // Register writes
    if (wr_en) begin
      nxt_r.on     = apb_req_i.pwdata[`ACS_CTRL_ON];
      nxt_r.rc_sel = apb_req_i.pwdata[`ACS_CTRL_RC];
    end
    if (wr_any && apb_req_i.paddr == `ACS_OFF_MASK) begin
      nxt_r.mask = apb_req_i.pwdata[`ACS_EV_W-1:0];
    end
    // Write one to clear; hardware sets below win over it
    if (wr_any && apb_req_i.paddr == `ACS_OFF_STAT) begin
      nxt_r.flags = r_ff.flags & ~apb_req_i.pwdata[`ACS_EV_W-1:0];
    end
    // Go only sticks when the module was already on, so a combined write
    // that turns the converter on does not start it
    if (go_rise && operational) begin
      nxt_r.go = 1'b1;
    end
    // Software cancel: stop early and keep the partial result
    if (go_fall) begin
      nxt_r.go = 1'b0;
      nxt_r.st = ACS_IDLE;
      sar_abort = (r_ff.st == ACS_CONV);
    end
    // Hardware trigger; ignored while a conversion is already pending
    if (trigger_i && operational && !r_ff.go) begin
      nxt_r.go   = 1'b1;
      nxt_r.tclr = 1'b1;
    end

    // Sequencer
    unique case (r_ff.st)
      ACS_IDLE: begin
        if (r_ff.go && operational && !go_fall) begin
          if (r_ff.rc_sel) begin
            nxt_r.st  = ACS_DELAY;
            nxt_r.dly = 3'h0;
          end else begin
            nxt_r.st  = ACS_CONV;
            sar_start = 1'b1;
          end
        end
      end
      ACS_DELAY: begin
        nxt_r.dly = r_ff.dly + 3'h1;
        if (r_ff.dly == 3'(INSTR_CYC - 1) && !go_fall) begin
          nxt_r.st  = ACS_CONV;
          sar_start = 1'b1;
        end
      end
      ACS_CONV: begin
        if (sar_done) begin
          nxt_r.st = ACS_IDLE;
          if (!go_rise) begin
            nxt_r.go = 1'b0;
          end
          if (sleep_i && r_ff.mask[`ACS_EV_DONE]) begin
            nxt_r.wake = 1'b1;
          end
          if (sleep_i && !r_ff.mask[`ACS_EV_DONE]) begin
            nxt_r.pdown = 1'b1;
          end
        end
      end
    endcase
    if (sar_done) begin
      nxt_r.flags[`ACS_EV_DONE] = 1'b1;
    end
    // Completed and partial results both land here
    if (sar_load) begin
      nxt_r.res = sar_result;
    end

    // Sleep without the RC clock: abort and power the module down, converter_on kept
    if (sleep_i && !r_ff.rc_sel && r_ff.on) begin
      nxt_r.pdown = 1'b1;
      if (r_ff.st != ACS_IDLE || r_ff.go) begin
        nxt_r.go = 1'b0;
        nxt_r.st = ACS_IDLE;
        nxt_r.flags[`ACS_EV_ABORT] = 1'b1;
        sar_kill = 1'b1;
      end
    end
    // Switching off while go stays set kills the conversion without a result
    if (!r_ff.on && r_ff.st != ACS_IDLE) begin
      nxt_r.go = 1'b0;
      nxt_r.st = ACS_IDLE;
      sar_kill = 1'b1;
    end
    // Leaving sleep powers the module back up
    if (!sleep_i) begin
      nxt_r.pdown = 1'b0;
    end

    nxt_r.aen = nxt_r.on && !nxt_r.pdown;
    nxt_r.irq = |(nxt_r.flags & nxt_r.mask);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      r_ff <= '{st: ACS_IDLE, res: `ACS_RESULT_RST, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Code register mirrors the engine flop directly
  assign sar_code_o    = sar_code;
  assign apb_rsp_o     = r_ff.rsp;
  assign analog_en_o   = r_ff.aen;
  assign irq_o         = r_ff.irq;
  assign wake_o        = r_ff.wake;
  assign timer_clear_o = r_ff.tclr;
endmodule

// *** test/acs_properties.sv ***
// Concurrent checks on the conversion sequencer's ports
`timescale 1ns/1ns
`include "acs_defines.svh"
module acs_seq_props
  import acs_pkg::*;
#(
  parameter int RES_W = `ACS_RES_W
) (
  // Clock and reset
  input wire logic                  core_clk_i,
  input wire logic                  reset_n_i,
  // Bus and events
  input wire acs_pkg::acs_apb_req_t apb_req_i,
  input wire acs_pkg::acs_apb_rsp_t apb_rsp_o,
  input wire logic                  sleep_i,
  input wire logic                  trigger_i,
  input wire logic                  cmp_i,
  // Outputs watched
  input wire logic [RES_W-1:0]      sar_code_o,
  input wire logic                  analog_en_o,
  input wire logic                  irq_o,
  input wire logic                  wake_o,
  input wire logic                  timer_clear_o
);
  // ------------------------------------------------------------
  // Shared clocking and bus steps
  // ------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // One wait state: nothing on the first access cycle, answer on the second
  sequence setup_s;
    apb_req_i.psel && !apb_req_i.penable;
  endsequence
  sequence answer_s;
    !apb_rsp_o.pready ##1 apb_rsp_o.pready;
  endsequence

  apb_wait_a: assert property (setup_s |=> answer_s)
    else $error("pready not on second access cycle");
  pready_pulse_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("pready held longer than one cycle");
  write_rdata_a: assert property (apb_req_i.pwrite && apb_rsp_o.pready |->
    apb_rsp_o.prdata == 32'h0000_0000) else $error("read data not zero on a write");
  unmapped_err_a: assert property (setup_s ##0 apb_req_i.paddr > `ACS_OFF_STATE |=>
    ##1 apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setup_s ##0 apb_req_i.paddr <= `ACS_OFF_STATE |=>
    ##1 !apb_rsp_o.pslverr) else $error("mapped access refused");
  // Outputs come out of reset quiet
  reset_quiet_a: assert property ($rose(reset_n_i) |-> !irq_o && !wake_o &&
    !analog_en_o && !timer_clear_o && sar_code_o == '0) else $error("outputs busy after reset");
  // Wake only follows a conversion finished in sleep
  wake_cause_a: assert property (wake_o |-> $past(sleep_i))
    else $error("wake without sleep");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  // Timer clear answers an accepted trigger, once
  tclr_cause_a: assert property (timer_clear_o |-> $past(trigger_i))
    else $error("timer clear without trigger");
  tclr_pulse_a: assert property (timer_clear_o |=> !timer_clear_o)
    else $error("timer clear longer than one cycle");
endmodule

bind acs_sequencer acs_seq_props #(.RES_W(RES_W)) props_u (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .sleep_i(sleep_i), .trigger_i(trigger_i), .cmp_i(cmp_i),
  .sar_code_o(sar_code_o), .analog_en_o(analog_en_o), .irq_o(irq_o), .wake_o(wake_o),
  .timer_clear_o(timer_clear_o));

// *** test/tb_top.sv ***
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`include "acs_defines.svh"
module tb_top;
  import acs_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  localparam int TAD = 8;  // Equal bit periods, so the RC start lag stands out alone
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  acs_apb_req_t req = '0;
  acs_apb_rsp_t rsp;
  logic         slp = 1'b0;
  logic         trg = 1'b0;
  logic         cmp = 1'b0;
  logic [9:0]   code;
  logic         aen, irq, wake, tclr;
  logic [15:0]  seed = 16'h0034;
  logic [31:0]  q;
  logic         err;
  int           mismatches = 0;
  int           compares = 0;
  int           vin = 0;
  int           t_sys, t_rc, r;

  always #10 clk = ~clk;
  // Ideal comparator model of the analog input
  always @(posedge clk) cmp <= (rst_n === 1'b1) && (int'(code) <= vin);

  acs_sequencer #(.TAD_SYS_CYC(TAD), .TAD_RC_CYC(TAD)) dut_u (
    .core_clk_i(clk), .reset_n_i(rst_n), .apb_req_i(req), .apb_rsp_o(rsp),
    .sleep_i(slp), .trigger_i(trg), .cmp_i(cmp), .sar_code_o(code),
    .analog_en_o(aen), .irq_o(irq), .wake_o(wake), .timer_clear_o(tclr));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // APB transfer: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask

  task automatic regs_zero();
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0000_0000, "reg_reset");
  endtask

  // Linear feedback shift register step
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Next analog input from the shift register
  task automatic nxt();
    seed = lfsr(seed);
    vin = int'(seed[9:0]);
  endtask

  // Write control, then count cycles until the first trial code
  task automatic start(input logic [31:0] c, output int t);
    apb(1'b1, `ACS_OFF_CTRL, c);
    t = 0;
    while (code === 10'h000 && t < 500) begin
      @(posedge clk);
      t++;
    end
    // A start that never shows a trial code is a failure
    if (code === 10'h000) begin
      mismatches++;
      end_sim();
    end
  endtask

  // Poll go until hardware clears it
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, `ACS_OFF_CTRL, 32'h0000_0000);
      n++;
    end while (q[`ACS_CTRL_GO] !== 1'b0 && n < 200);
    if (n >= 200) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic wait_sig(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (s !== v) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic chk_res(input int v);
    rd(`ACS_OFF_RES_HI, 32'(v >> 8), "result_high");
    rd(`ACS_OFF_RES_LO, 32'(v & 255), "result_low");
  endtask

  // A cut-short result: decided bits, then the last decided bit repeated
  function automatic bit part_ok(input int v, input int g);
    int e;
    part_ok = (g == 0);
    for (int k = 1; k <= 10; k++) begin
      e = (v >> (10 - k)) << (10 - k);
      if (((v >> (10 - k)) & 1) == 1) e = e | ((1 << (10 - k)) - 1);
      if (g == e) part_ok = 1'b1;
    end
  endfunction

  task automatic pulse_trg();
    @(posedge clk);
    trg <= 1'b1;
    @(posedge clk);
    trg <= 1'b0;
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    regs_zero();
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, 32'(err));
    chk("analog_en", 32'h0000_0000, 32'(aen));
    // On and go together must not start
    apb(1'b1, `ACS_OFF_CTRL, 32'h0000_0003);
    rd(`ACS_OFF_CTRL, 32'h0000_0001, "ctrl_on_go");
    apb(1'b1, `ACS_OFF_MASK, 32'h0000_0001);
    // System clock runs; the done flag survives a new start
    for (int i = 0; i < 3; i++) begin
      nxt();
      start(32'h0000_0003, t_sys);
      rd(`ACS_OFF_STAT, (i > 0) ? 32'h0000_0001 : 32'h0000_0000, "flag_kept");
      wait_done();
      chk("irq", 32'h0000_0001, 32'(irq));
      rd(`ACS_OFF_STAT, 32'h0000_0001, "done_flag");
      chk_res(vin);
    end
    apb(1'b1, `ACS_OFF_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq_clear", 32'h0000_0000, 32'(irq));
    // RC clock: later start, runs in sleep, wakes the core
    apb(1'b1, `ACS_OFF_CTRL, 32'h0000_0005);
    nxt();
    start(32'h0000_0007, t_rc);
    chk("rc_start_lag", 32'h0000_0004, 32'(t_rc - t_sys));
    slp <= 1'b1;
    wait_sig(wake, 1'b1);
    chk("wake", 32'h0000_0001, 32'(wake));
    slp <= 1'b0;
    chk_res(vin);
    // RC clock, masked: powers down but stays on
    apb(1'b1, `ACS_OFF_MASK, 32'h0000_0000);
    apb(1'b1, `ACS_OFF_STAT, 32'h0000_0003);
    nxt();
    start(32'h0000_0007, t_rc);
    slp <= 1'b1;
    wait_sig(aen, 1'b0);
    rd(`ACS_OFF_STATE, 32'h0000_0004, "powered_down");
    rd(`ACS_OFF_CTRL, 32'h0000_0005, "on_kept");
    chk("irq_masked", 32'h0000_0000, 32'(irq));
    chk_res(vin);
    slp <= 1'b0;
    // System clock: sleep aborts, converter_on stays
    apb(1'b1, `ACS_OFF_CTRL, 32'h0000_0001);
    apb(1'b1, `ACS_OFF_MASK, 32'h0000_0003);
    apb(1'b1, `ACS_OFF_STAT, 32'h0000_0003);
    nxt();
    start(32'h0000_0003, t_sys);
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`ACS_OFF_CTRL, 32'h0000_0001, "abort_ctrl");
    rd(`ACS_OFF_STAT, 32'h0000_0002, "abort_flag");
    chk("abort_aen", 32'h0000_0000, 32'(aen));
    chk("abort_irq", 32'h0000_0001, 32'(irq));
    slp <= 1'b0;
    apb(1'b1, `ACS_OFF_STAT, 32'h0000_0002);
    // Early stop at several depths of the conversion
    for (int j = 0; j < 3; j++) begin
      nxt();
      start(32'h0000_0003, t_sys);
      repeat (5 + 27 * j) @(posedge clk);
      apb(1'b1, `ACS_OFF_CTRL, 32'h0000_0001);
      repeat (3) @(posedge clk);
      apb(1'b0, `ACS_OFF_RES_HI, 32'h0000_0000);
      r = int'(q) << 8;
      apb(1'b0, `ACS_OFF_RES_LO, 32'h0000_0000);
      r = r | int'(q);
      chk("partial", 32'h0000_0001, 32'(part_ok(vin, r)));
      rd(`ACS_OFF_STAT, 32'h0000_0000, "no_done");
    end
    // Hardware trigger; a second one while busy is ignored
    nxt();
    pulse_trg();
    chk("timer_clear", 32'h0000_0001, 32'(tclr));
    rd(`ACS_OFF_CTRL, 32'h0000_0003, "trig_go");
    pulse_trg();
    chk("trig_busy", 32'h0000_0000, 32'(tclr));
    wait_done();
    chk_res(vin);
    // Reset in mid-conversion
    nxt();
    start(32'h0000_0003, t_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("reset_code", 32'h0000_0000, 32'(code));
    regs_zero();
    end_sim();
  end
endmodule
